// ===== rtl/rxu_pkg.sv
// ---------------------------------------------------------------
// Shared constants of the serial receive path
// ---------------------------------------------------------------
package rxu_pkg;

   // Oversampling: sixteen receive clock ticks per bit
   localparam int RXU_OVS = 16;
   // Tick count at the middle of the start bit
   localparam logic [3:0] RXU_MID = 4'h7;
   // Tick count at which a data, parity or stop bit is taken
   localparam logic [3:0] RXU_LAST = 4'hf;

   // Receive FIFO depth and its pointer width
   localparam int RXU_FIFO_DEPTH = 16;
   localparam int RXU_PTR_W = 4;
   // Capacity of the single holding register when FIFOs are off
   localparam logic [4:0] RXU_HOLD_CAP = 5'h01;
   // Capacity of the FIFO when enabled
   localparam logic [4:0] RXU_FIFO_CAP = 5'h10;

   // Trigger levels chosen by the two trigger select bits
   localparam logic [4:0] RXU_TRIG_1 = 5'h01;
   localparam logic [4:0] RXU_TRIG_4 = 5'h04;
   localparam logic [4:0] RXU_TRIG_8 = 5'h08;
   localparam logic [4:0] RXU_TRIG_14 = 5'h0e;

   // Character timeout in character times
   localparam int RXU_TMO_CHARS = 4;

   // Index of the last data bit for the shortest word (five bits)
   localparam logic [2:0] RXU_MIN_LAST = 3'h4;

   // Reset values
   localparam logic RXU_LINE_IDLE = 1'b1;
   localparam logic [15:0] RXU_BAUD_RST = 16'h0000;

   // Receiver states, one-hot
   typedef enum logic [4:0] {
      RXU_IDLE = 5'b00001,
      RXU_START = 5'b00010,
      RXU_DATA = 5'b00100,
      RXU_PAR = 5'b01000,
      RXU_STOP = 5'b10000
   } rxu_state_t;

endpackage : rxu_pkg

// ===== rtl/rxu_buf2.sv
`timescale 1ns/10ps
// Two-entry buffer between the receive FIFO and the reader
module rxu_buf2 #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   // Occupancy
   output logic [1:0] count
);
   import rxu_pkg::*;

   logic [W-1:0] d0_r, d0_nxt; // Head entry
   logic [W-1:0] d1_r, d1_nxt; // Second entry
   logic [1:0] cnt_r, cnt_nxt; // Entries held
   logic push, pop;
   logic [1:0] tgt;

   assign in_ready = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data = d0_r;
   assign count = cnt_r;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      d0_nxt = d0_r;
      d1_nxt = d1_r;
      // Shift forward first so a push lands in the slot left free
      if (pop) begin
         d0_nxt = d1_r;
      end
      tgt = cnt_r - {1'b0, pop};
      if (push && tgt == 2'h0) begin
         d0_nxt = in_data;
      end else if (push) begin
         d1_nxt = in_data;
      end
      cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
   end

   // Registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         d0_r <= '0;
         d1_r <= '0;
         cnt_r <= 2'h0;
      end else begin
         d0_r <= d0_nxt;
         d1_r <= d1_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // A held word stays put until the reader takes it
   property p_hold_stall;
      out_valid && !out_ready |=> out_valid && out_data == $past(out_data);
   endproperty
   a_hold_stall: assert property (p_hold_stall) else $error("buffered word changed while stalled");

endmodule : rxu_buf2

// ===== rtl/rxu_receiver.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1: Each bit spans sixteen receive clock ticks.
// R2: Receive ticks come from the baud generator.
// R3: Line pulses under two ticks are ignored.
// R4: Finished characters go to holding register/FIFO.
// R5: First received data bit lands in bit zero.
// R6: Check parity and stop bit, flag mismatch.
// R7: Data interrupt on arrival or trigger level.
// R8: Interrupts for timeout, parity, framing, line errors.
// R9: FIFO enable bit gives sixteen byte buffering; the code holds 18 (sixteen FIFO entries plus the two-entry output buffer).
// R10: Trigger levels are one, four, eight, fourteen.
// R11: Five to eight data bits, configurable parity/stop.
// R12: Sixteen-bit divisor, values one to 65535.
// R13: Sender sends start, data LSB first, parity, stops.
// R14: Timeout after about four idle character times.
// R15: Character arriving when full sets overrun, dropped.
module rxu_receiver (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Serial receive line
   input wire logic rx_line,
   // Baud divisor
   input wire logic [15:0] divisor,
   // Line control
   input wire logic [1:0] word_len,
   input wire logic stop_two,
   input wire logic par_en,
   input wire logic par_even,
   input wire logic par_stick,
   // FIFO control
   input wire logic fifo_en,
   input wire logic [1:0] trig_sel,
   input wire logic err_clr,
   // Interrupt enables
   input wire logic rda_ie,
   input wire logic rls_ie,
   // Received data to the reader
   output logic [7:0] rd_data,
   output logic rd_valid,
   input wire logic rd_ready,
   // Status
   output logic [4:0] level,
   output logic parity_err,
   output logic frame_err,
   output logic overrun_err,
   output logic rda_irq,
   output logic tmo_irq,
   output logic rls_irq
);
   import rxu_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [15:0] bcnt_r, bcnt_nxt; // Baud divider count
   logic [15:0] div_eff; // Divisor with zero treated as one
   logic tick; // One receive clock period elapsed
   logic [1:0] samp_r, samp_nxt; // Last two line samples
   logic filt_r, filt_nxt; // Filtered line level
   rxu_state_t st_r, st_nxt; // Receiver state
   logic [3:0] os_r, os_nxt; // Tick count within a bit
   logic [2:0] bit_r, bit_nxt; // Data bit index
   logic [7:0] sh_r, sh_nxt; // Receive shift register
   logic pbit_r, pbit_nxt; // Received parity bit
   logic [2:0] bit_last; // Index of last data bit
   logic done; // Stop bit taken this cycle
   logic stop_ok; // Stop bit was high
   logic par_exp; // Expected parity bit
   logic [7:0] mem [RXU_FIFO_DEPTH]; // Receive FIFO storage
   logic [RXU_PTR_W-1:0] wr_r, wr_nxt, rd_r, rd_nxt; // FIFO pointers
   logic [4:0] cnt_r, cnt_nxt; // FIFO occupancy
   logic [4:0] cap; // Capacity in the current mode
   logic fen_r; // FIFO enable of last cycle
   logic push, pop, ovr, flush;
   logic buf_ready;
   logic [1:0] buf_cnt;
   logic pe_r, pe_nxt, fe_r, fe_nxt, oe_r, oe_nxt; // Sticky line errors
   logic [9:0] tcnt_r, tcnt_nxt; // Idle ticks with data waiting
   logic tmo_r, tmo_nxt; // Timeout pending
   logic [3:0] frame_bits; // Bits in one character frame
   logic [9:0] tmo_lim;
   logic [4:0] trig;

   // ---------------------------------------------------------------
   // Baud generator
   // ---------------------------------------------------------------
   // Divides the system clock; one tick is one receive clock period
   always_comb begin
      div_eff = (divisor == 16'h0000) ? 16'h0001 : divisor; // [R12]
      tick = (bcnt_r >= div_eff - 16'h0001); // [R2]
      bcnt_nxt = tick ? 16'h0000 : bcnt_r + 16'h0001;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bcnt_r <= RXU_BAUD_RST;
      end else begin
         bcnt_r <= bcnt_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Line filter
   // ---------------------------------------------------------------
   // A new level is taken only after two equal samples in a row
   always_comb begin
      samp_nxt = samp_r;
      filt_nxt = filt_r;
      if (tick) begin
         samp_nxt = {samp_r[0], rx_line};
         if (samp_r[1] == samp_r[0]) begin
            filt_nxt = samp_r[0]; // [R3]
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         samp_r <= {RXU_LINE_IDLE, RXU_LINE_IDLE};
         filt_r <= RXU_LINE_IDLE;
      end else begin
         samp_r <= samp_nxt;
         filt_r <= filt_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Character framing
   // ---------------------------------------------------------------
   assign bit_last = RXU_MIN_LAST + {1'b0, word_len}; // [R11]

   // Start checked mid-bit, then every bit taken sixteen ticks apart
   always_comb begin
      st_nxt = st_r;
      os_nxt = os_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      pbit_nxt = pbit_r;
      done = 1'b0;
      stop_ok = 1'b1;
      if (tick) begin
         os_nxt = os_r + 4'h1; // [R1]
         unique case (st_r)
            RXU_IDLE: begin
               os_nxt = 4'h0;
               if (!filt_r) begin
                  st_nxt = RXU_START;
               end
            end
            RXU_START: begin
               // A start bit gone high by mid-bit was noise
               if (os_r == RXU_MID) begin
                  os_nxt = 4'h0;
                  bit_nxt = 3'h0;
                  sh_nxt = 8'h00;
                  st_nxt = filt_r ? RXU_IDLE : RXU_DATA;
               end
            end
            RXU_DATA: begin
               if (os_r == RXU_LAST) begin
                  sh_nxt[bit_r] = filt_r; // [R5] [R13]
                  bit_nxt = bit_r + 3'h1;
                  if (bit_r == bit_last) begin
                     st_nxt = par_en ? RXU_PAR : RXU_STOP;
                  end
               end
            end
            RXU_PAR: begin
               if (os_r == RXU_LAST) begin
                  pbit_nxt = filt_r;
                  st_nxt = RXU_STOP;
               end
            end
            RXU_STOP: begin
               // Only the first stop bit is checked; extra ones look idle
               if (os_r == RXU_LAST) begin
                  done = 1'b1; // [R4]
                  stop_ok = filt_r; // [R6]
                  st_nxt = RXU_IDLE;
               end
            end
            default: begin
               st_nxt = RXU_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= RXU_IDLE;
         os_r <= 4'h0;
         bit_r <= 3'h0;
         sh_r <= 8'h00;
         pbit_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         os_r <= os_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         pbit_r <= pbit_nxt;
      end
   end

   // Unused high bits of the shift register are zero, so a full XOR works
   assign par_exp = par_stick ? ~par_even : (par_even ? ^sh_r : ~^sh_r); // [R6]

   // ---------------------------------------------------------------
   // Holding register / receive FIFO
   // ---------------------------------------------------------------
   // Capacity one without FIFOs, sixteen with them
   always_comb begin
      cap = fifo_en ? RXU_FIFO_CAP : RXU_HOLD_CAP; // [R9]
      flush = (fifo_en != fen_r);
      push = done && (cnt_r != cap) && !flush;
      ovr = done && (cnt_r == cap); // [R15]
      pop = (cnt_r != 5'h00) && buf_ready && !flush;
      wr_nxt = wr_r;
      rd_nxt = rd_r;
      cnt_nxt = cnt_r;
      // Switching mode empties the FIFO so stale bytes never mix in
      if (flush) begin
         wr_nxt = '0;
         rd_nxt = '0;
         cnt_nxt = 5'h00;
      end else begin
         wr_nxt = wr_r + {{(RXU_PTR_W-1){1'b0}}, push}; // [R4]
         rd_nxt = rd_r + {{(RXU_PTR_W-1){1'b0}}, pop};
         cnt_nxt = cnt_r + {4'h0, push} - {4'h0, pop};
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= 5'h00;
         fen_r <= 1'b0;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
         fen_r <= fifo_en;
      end
   end

   // Storage has no reset; occupancy decides what is valid
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_r] <= sh_r;
      end
   end

   // Output stage so a stalled reader loses no word
   rxu_buf2 #(.W(8)) u_buf (
      .clk(clk),
      .arst_n(arst_n),
      .in_valid((cnt_r != 5'h00) && !flush),
      .in_ready(buf_ready),
      .in_data(mem[rd_r]),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data),
      .count(buf_cnt)
   );

   assign level = cnt_r + {3'h0, buf_cnt};

   // ---------------------------------------------------------------
   // Line errors
   // ---------------------------------------------------------------
   // Sticky; a new error in the clearing cycle survives the clear
   always_comb begin
      pe_nxt = (err_clr ? 1'b0 : pe_r) | (done && par_en && pbit_r != par_exp); // [R6]
      fe_nxt = (err_clr ? 1'b0 : fe_r) | (done && !stop_ok); // [R6]
      oe_nxt = (err_clr ? 1'b0 : oe_r) | ovr; // [R15]
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pe_r <= 1'b0;
         fe_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         pe_r <= pe_nxt;
         fe_r <= fe_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign parity_err = pe_r;
   assign frame_err = fe_r;
   assign overrun_err = oe_r;

   // ---------------------------------------------------------------
   // Character timeout
   // ---------------------------------------------------------------
   // Frame length follows the line settings; 1.5 stops count as two
   always_comb begin
      frame_bits = 4'h3 + {1'b0, bit_last} + {3'h0, par_en} + {3'h0, stop_two};
      tmo_lim = 10'({6'h0, frame_bits} * 10'(RXU_OVS * RXU_TMO_CHARS));
      tcnt_nxt = tcnt_r;
      tmo_nxt = tmo_r;
      // Any arrival, read or empty FIFO restarts the wait
      if (done || (rd_valid && rd_ready) || level == 5'h00 || !fifo_en) begin
         tcnt_nxt = 10'h000;
         tmo_nxt = 1'b0;
      end else if (tick) begin
         if (tcnt_r >= tmo_lim - 10'h001) begin
            tmo_nxt = 1'b1; // [R14]
         end else begin
            tcnt_nxt = tcnt_r + 10'h001;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tcnt_r <= 10'h000;
         tmo_r <= 1'b0;
      end else begin
         tcnt_r <= tcnt_nxt;
         tmo_r <= tmo_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt requests
   // ---------------------------------------------------------------
   always_comb begin
      unique case (trig_sel)
         2'h0: trig = RXU_TRIG_1; // [R10]
         2'h1: trig = RXU_TRIG_4;
         2'h2: trig = RXU_TRIG_8;
         2'h3: trig = RXU_TRIG_14;
      endcase
      rda_irq = rda_ie && (fifo_en ? (level >= trig) : (level != 5'h00)); // [R7]
      tmo_irq = rda_ie && tmo_r; // [R8]
      rls_irq = rls_ie && (pe_r || fe_r || oe_r); // [R8]
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   property p_tick_gap;
      tick && div_eff > 16'h0001 && $stable(divisor) |=> !tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("receive ticks too close"); // [R2] [R12]

   property p_bit_spacing;
      st_r == RXU_DATA && bit_nxt != bit_r |-> os_r == RXU_LAST && tick;
   endproperty
   a_bit_spacing: assert property (p_bit_spacing) else $error("data bit taken off sixteenth tick"); // [R1]

   property p_filter;
      filt_r != $past(filt_r) |-> $past(samp_r[1]) == filt_r && $past(samp_r[0]) == filt_r;
   endproperty
   a_filter: assert property (p_filter) else $error("line level taken from one sample"); // [R3]

   property p_false_start;
      st_r == RXU_START && tick && os_r == RXU_MID && filt_r |=> st_r == RXU_IDLE;
   endproperty
   a_false_start: assert property (p_false_start) else $error("noise start not rejected"); // [R3]

   property p_store;
      push |=> mem[$past(wr_r)] == $past(sh_r) && cnt_r != 5'h00;
   endproperty
   a_store: assert property (p_store) else $error("character not stored"); // [R4] [R5]

   property p_frame;
      st_r == RXU_STOP && tick && os_r == RXU_LAST && !filt_r |=> frame_err;
   endproperty
   a_frame: assert property (p_frame) else $error("missing stop bit not flagged"); // [R6]

   property p_hold_cap;
      !fifo_en && !$past(fifo_en) |-> cnt_r <= RXU_HOLD_CAP;
   endproperty
   a_hold_cap: assert property (p_hold_cap) else $error("holding register over capacity"); // [R9]

   property p_trig14;
      fifo_en && trig_sel == 2'h3 && rda_irq |-> level >= 5'h0e;
   endproperty
   a_trig14: assert property (p_trig14) else $error("data interrupt below trigger"); // [R7] [R10]

   property p_overrun;
      done && cnt_r == cap && !flush |=> overrun_err && cnt_r <= $past(cnt_r);
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged or char kept"); // [R15]

   property p_timeout;
      $rose(tmo_r) |-> level != 5'h00 && fifo_en;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout with FIFO empty"); // [R14]

endmodule : rxu_receiver

// ===== sim/rxu_tx_model.sv
`timescale 1ns/10ps
// -------------------------------------------------------------
// Remote serial sender that faces the receive line
// -------------------------------------------------------------
module rxu_tx_model (
   // Clock
   input wire logic clk,
   // Bit period control, same divisor as the receiver
   input wire logic [15:0] divisor,
   // Serial line toward the receiver
   output logic rx_line
);
   // The line idles high between frames
   initial rx_line = 1'b1;

   // Hold one level for a number of receive ticks, ending just after an edge
   task automatic hold(input logic v, input int ticks);
      rx_line = v;
      // A zero divisor acts as one, as it does in the receiver
      repeat (ticks * ((divisor == 16'h0000) ? 1 : int'(divisor))) @(posedge clk);
      #1;
   endtask : hold

   // One character; bad_par and bad_stop break the frame only on demand
   task automatic send(input logic [7:0] d, input int nb, input logic pe, input logic ev,
                       input logic st, input logic bad_par, input logic bad_stop);
      logic x;
      x = 1'b0;
      hold(1'b0, 16); // start bit first
      for (int i = 0; i < nb; i++) begin
         hold(d[i], 16); // data bits, least significant first
         x = x ^ d[i];
      end
      if (pe) begin
         // Sticky parity sends the inverse of the even select
         hold((st ? ~ev : (ev ? x : ~x)) ^ bad_par, 16); // parity after data
      end
      hold(~bad_stop, 16); // stop bit last
      if (bad_stop) begin
         // Return to idle so the low stop is not taken as a new start
         hold(1'b1, 16);
      end
   endtask : send

   // A single-tick low pulse, too short to be a level change
   task automatic glitch;
      hold(1'b0, 1);
      rx_line = 1'b1;
   endtask : glitch
endmodule : rxu_tx_model

// ===== sim/testbench.sv
`timescale 1ns/10ps
// -------------------------------------------------------------
// Self-checking bench of the receive path
// -------------------------------------------------------------
module testbench;
   import rxu_pkg::*;
   // Design inputs, all set at time zero
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic rx_line;
   logic [15:0] divisor = 16'h0001;
   logic [1:0] word_len = 2'h3;
   logic stop_two = 1'b0, par_en = 1'b0, par_even = 1'b0, par_stick = 1'b0;
   logic fifo_en = 1'b1, err_clr = 1'b0, rda_ie = 1'b1, rls_ie = 1'b1, rd_ready = 1'b0;
   logic [1:0] trig_sel = 2'h0;
   // Design outputs
   logic [7:0] rd_data;
   logic [4:0] level;
   logic rd_valid, parity_err, frame_err, overrun_err, rda_irq, tmo_irq, rls_irq;
   // Bench state: counters, reader gate, random source, expected words
   int failures = 0, cmp_count = 0, cycles = 0;
   logic drain_en = 1'b0;
   logic [15:0] lfsr = 16'ha256;
   logic [7:0] exp_q[$];
   int trg[4] = '{1, 4, 8, 14};

   always #10 clk = ~clk;

   rxu_tx_model tx (.clk(clk), .divisor(divisor), .rx_line(rx_line));
   rxu_receiver dut (.clk(clk), .arst_n(arst_n), .rx_line(rx_line), .divisor(divisor), .word_len(word_len),
      .stop_two(stop_two), .par_en(par_en), .par_even(par_even), .par_stick(par_stick), .fifo_en(fifo_en),
      .trig_sel(trig_sel), .err_clr(err_clr), .rda_ie(rda_ie), .rls_ie(rls_ie), .rd_data(rd_data),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .level(level), .parity_err(parity_err),
      .frame_err(frame_err), .overrun_err(overrun_err), .rda_irq(rda_irq), .tmo_irq(tmo_irq), .rls_irq(rls_irq));

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr_next

   task automatic chk8(input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk8

   task automatic chk5(input logic [4:0] e, input logic [4:0] g);
      chk8({3'h0, e}, {3'h0, g});
   endtask : chk5

   task automatic chk1(input logic e, input logic g);
      chk8({7'h00, e}, {7'h00, g});
   endtask : chk1

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test

   // Wait n edges and land just after the last one
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   // Expect a word only while the buffered stages are below cap
   task automatic put(input logic [7:0] d, input int nb, input logic bp, input logic bs, input int cap);
      if (exp_q.size() < cap) begin
         exp_q.push_back(d & (8'hff >> (8 - nb)));
      end
      tx.send(d, nb, par_en, par_even, par_stick, bp, bs);
      cyc(3);
   endtask : put

   // Let the reader empty everything, then clear sticky flags
   task automatic drain;
      drain_en = 1'b1;
      for (int n = 0; n < 400 && level !== 5'h00; n++) cyc(1);
      cyc(4);
      drain_en = 1'b0;
      err_clr = 1'b1;
      cyc(1);
      err_clr = 1'b0;
      chk5(5'h00, level);
      chk5(5'h00, 5'(exp_q.size()));
   endtask : drain

   // -------------------------------------------------------------
   // Reader and watchdog
   // -------------------------------------------------------------
   // Ready wanders randomly so the buffer sees stalls
   always @(posedge clk) begin
      lfsr <= lfsr_next(lfsr);
      rd_ready <= #1 drain_en & lfsr[0];
   end

   // Words are compared at mid-cycle, where the handshake is settled
   always @(negedge clk) begin
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
         chk8((exp_q.size() > 0) ? exp_q.pop_front() : ~rd_data, rd_data); // order and bit 0 first
      end
   end

   // A hang counts as a mismatch and closes the run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         end_of_test();
      end
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      #1 arst_n = 1'b1;
      cyc(1);
      chk5(5'h00, level);
      chk1(1'b0, rd_valid | parity_err | frame_err | overrun_err | rda_irq | tmo_irq | rls_irq);
      // Every word length under every parity mode, reader draining
      drain_en = 1'b1;
      for (int m = 0; m < 5; m++) begin
         for (int w = 0; w < 4; w++) begin
            word_len = w[1:0];
            par_en = (m != 0);
            par_even = (m == 2 || m == 4);
            par_stick = (m >= 3);
            put(lfsr[7:0], 5 + w, 1'b0, 1'b0, 99); // formats
         end
      end
      chk1(1'b0, parity_err | frame_err); // good frames raise no error
      drain;
      // Bad parity, then a missing stop bit
      par_en = 1'b1;
      par_even = 1'b1;
      par_stick = 1'b0;
      for (int e = 0; e < 2; e++) begin
         put(8'h5a, 8, e == 0, e == 1, 99);
         chk1(e == 0, parity_err); // parity
         chk1(e == 1, frame_err); // stop bit
         chk1(1'b1, rls_irq); // line error interrupt
         rls_ie = 1'b0;
         cyc(1);
         chk1(1'b0, rls_irq); // masked line interrupt
         rls_ie = 1'b1;
         drain;
         chk1(1'b0, parity_err | frame_err | rls_irq);
      end
      // A one-tick low pulse stores nothing
      par_en = 1'b0;
      tx.glitch();
      // The filtered level must never follow the one-tick pulse
      for (int n = 0; n < 6; n++) begin
         chk1(1'b1, dut.filt_r); // short pulse not taken as a level
         cyc(1);
      end
      cyc(400);
      chk5(5'h00, level); // short pulse filtered
      // Fill the FIFO past its depth while the reader stalls
      for (int k = 1; k <= 19; k++) begin
         put(lfsr[7:0], 8, 1'b0, 1'b0, 18);
         chk5(5'((k < 18) ? k : 18), level); // sixteen deep plus buffer
         for (int t = 0; t < 4; t++) begin
            trig_sel = t[1:0];
            cyc(1);
            chk1(((k < 18) ? k : 18) >= trg[t], rda_irq); // trigger levels
         end
         chk1(k == 19, overrun_err); // overrun on a full FIFO
      end
      rda_ie = 1'b0;
      cyc(1);
      chk1(1'b0, rda_irq); // masked data interrupt
      rda_ie = 1'b1;
      drain;
      // Character timeout after four idle frames of ten, then eleven bits
      for (int s = 0; s < 2; s++) begin
         stop_two = s[0];
         put(lfsr[7:0], 8, 1'b0, 1'b0, 99);
         for (int n = 0; n < 900; n++) begin
            if (tmo_irq === 1'b1 || n == 899) begin
               chk1(1'b1, n >= 600 + 64 * s && n <= 680 + 64 * s); // timeout span
               break;
            end
            cyc(1);
         end
         drain;
         chk1(1'b0, tmo_irq); // read clears the timeout
      end
      stop_two = 1'b0;
      // Holding register mode: one stage plus the output buffer
      fifo_en = 1'b0;
      trig_sel = 2'h3;
      cyc(2);
      for (int k = 1; k <= 4; k++) begin
         put(lfsr[7:0], 8, 1'b0, 1'b0, 3);
         chk5(5'((k < 3) ? k : 3), level); // single holding stage
         chk1(1'b1, rda_irq); // arrival interrupt without FIFO
         chk1(k == 4, overrun_err); // overrun on a full holding stage
      end
      drain;
      // Zero divisor acts as one, then slower bit rates from larger divisors
      fifo_en = 1'b1;
      drain_en = 1'b1;
      for (int d = 0; d <= 3; d++) begin
         divisor = 16'(d);
         put(lfsr[7:0], 8, 1'b0, 1'b0, 99); // divided tick rate
      end
      drain;
      end_of_test();
   end
endmodule : testbench
